// ---- rtl/rtcs_defines.svh ----
// Register indices, field positions, masks and reset values of the clock control block.
`ifndef RTCS_DEFINES_SVH
`define RTCS_DEFINES_SVH

// ------------------------------------------------------------------
// Register keys: {bank, index}; byte address is four times the key.
// ------------------------------------------------------------------
`define RTCS_KEY_CTRL   8'h0B
`define RTCS_KEY_FLAGS  8'h0C
`define RTCS_KEY_VALID  8'h0D
`define RTCS_KEY_AUX    8'h7D
`define RTCS_KEY_PWR    8'h7E
`define RTCS_GP_LO      8'h0E
`define RTCS_GP_HI      8'h7C
`define RTCS_GP_TOP     8'h7F
`define RTCS_KEY_BANK   7

// ------------------------------------------------------------------
// Field positions.
// ------------------------------------------------------------------
`define RTCS_B_HALT     7
`define RTCS_B_PIE      6
`define RTCS_B_AIE      5
`define RTCS_B_UIE      4
`define RTCS_B_BIN      2
`define RTCS_B_H24      1
`define RTCS_F_ANY      7
`define RTCS_F_PF       6
`define RTCS_F_AF       5
`define RTCS_F_UF       4
`define RTCS_V_VALID    7
`define RTCS_P_XTAL     7
`define RTCS_P_PON      2
`define RTCS_P_POFF     1
`define RTCS_P_REM      0
`define RTCS_A_DAEN     0
`define RTCS_A_PCLR     1
`define RTCS_A_BUSY     7

// ------------------------------------------------------------------
// Masks, sizes and reset values.
// ------------------------------------------------------------------
`define RTCS_CTRL_WMASK 8'hF6
`define RTCS_PWR_WMASK  8'h87
`define RTCS_DATE_MASK  8'h3F
`define RTCS_FLAG_LOW   8'h0F
`define RTCS_RST_BYTE   8'h00
`define RTCS_RST_WORD   32'h0000_0000
`define RTCS_HSIZE_WORD 3'h2
`define RTCS_PIN_CNT    4
`define RTCS_PIN_IDLE   4'h2

`endif

// ---- rtl/rtcs_pkg.sv ----
// Types shared by the clock control block.
package rtcs_pkg;

   // Bus transfer kinds as published for AHB-Lite.
   typedef enum logic [1:0]
   {
      RTCS_IDLE   = 2'h0,
      RTCS_BUSY   = 2'h1,
      RTCS_NONSEQ = 2'h2,
      RTCS_SEQ    = 2'h3
   } rtcs_htrans_t;

   // One register byte.
   typedef logic [7:0] rtcs_byte_t;

endpackage : rtcs_pkg

// ---- rtl/rtcs_irq_ctrl.sv ----
// Interrupt, status, power wake control and CMOS storage of the real time clock.
//
// Chosen here: register access over AHB-Lite.
`timescale 1ns/10ps
`include "rtcs_defines.svh"

module rtcs_irq_ctrl
(
   input  wire logic                   CLK_SYS,
   input  wire logic                   RESETN,
   input  wire logic                   HSEL,
   input  wire logic [31:0]            HADDR,
   input  wire rtcs_pkg::rtcs_htrans_t HTRANS,
   input  wire logic                   HWRITE,
   input  wire logic [2:0]             HSIZE,
   input  wire logic [31:0]            HWDATA,
   input  wire logic                   HREADY,
   output logic      [31:0]            HRDATA,
   output logic                        HREADYOUT,
   output logic                        HRESP,
   input  wire logic                   SYSTEM_RESET_IN,
   input  wire logic                   TRICKLE_SUPPLY,
   input  wire logic                   STANDBY_POR,
   input  wire logic                   BATTERY_LOW,
   input  wire logic                   PERIODIC_TAP,
   input  wire logic                   ALARM_MATCH,
   input  wire logic                   UPDATE_DONE,
   input  wire logic                   UPDATE_BUSY,
   output logic                        IRQ_OUT_N,
   output logic                        SUPPLY_TURN_ON_N_O,
   output logic                        SUPPLY_TURN_ON_N_OE,
   output logic                        BINARY_FORMAT_SEL,
   output logic                        HOUR_24_SEL,
   output logic                        UPDATE_HALT,
   output logic                        CRYSTAL_LOAD_SEL,
   output logic                        DATE_ALARM_EN
);
   import rtcs_pkg::*;

   // ------------------------------------------------------------------
   // Declarations.
   // ------------------------------------------------------------------
   logic [`RTCS_PIN_CNT-1:0] sync1_r;       // First stage of the pin synchronisers.
   logic [`RTCS_PIN_CNT-1:0] sync2_r;       // Second stage, the only one logic reads.
   logic [`RTCS_PIN_CNT-1:0] pin_prev_r;    // Previous synchronised levels for edges.
   logic                     sys_rst;       // Synchronised system reset level.
   logic                     trickle_rise;  // Standby rail has just returned.
   logic                     por_evt;       // Standby-rail power-on reset event.
   logic                     batt_low;      // Synchronised low battery level.
   logic                     tap_prev_r;    // Previous periodic tap level.
   logic                     pf_evt;        // Periodic event pulse.
   rtcs_byte_t               ctrl_r;        // Format and enable control.
   rtcs_byte_t               ctrl_nxt;
   rtcs_byte_t               flags_r;       // Live flags in bits 6 to 4 only.
   rtcs_byte_t               flags_nxt;
   rtcs_byte_t               pwr_r;         // Battery backed power wake control.
   rtcs_byte_t               date_r;        // Date-of-month alarm value.
   logic                     daen_r;        // Date alarm enable.
   logic                     valid_r;       // Contents valid.
   logic                     alarm_missed_r;// Alarm passed while the standby rail was gone.
   logic                     power_req_r;   // Power-on output is being driven low.
   rtcs_byte_t               ram [256];     // General purpose CMOS bytes, both banks.
   logic                     acc;           // Address phase taken this edge.
   logic                     a_map;         // Address phase hits the register window.
   rtcs_byte_t               a_key;         // Address phase register key.
   logic                     rd_flags;      // Flag register read taken this edge.
   logic                     wr_pend_r;     // Write data phase in progress.
   rtcs_byte_t               wr_key_r;      // Key of the pending write.
   logic                     wr_ctrl;       // Pending write commits to the control register.
   rtcs_byte_t               rd_val;        // Read value for the address phase.

   // ------------------------------------------------------------------
   // Helper functions.
   // ------------------------------------------------------------------

   // Summary interrupt condition from flags and their enables.
   function automatic logic irq_any(input rtcs_byte_t fl, input rtcs_byte_t en);
      irq_any = (fl[`RTCS_F_PF] & en[`RTCS_B_PIE]) | (fl[`RTCS_F_AF] & en[`RTCS_B_AIE]) |
                (fl[`RTCS_F_UF] & en[`RTCS_B_UIE]);
   endfunction : irq_any

   // True where a key names a general purpose CMOS byte.
   function automatic logic is_gp(input rtcs_byte_t key);
      is_gp = key[`RTCS_KEY_BANK] | ((key >= `RTCS_GP_LO) & (key <= `RTCS_GP_HI)) | (key == `RTCS_GP_TOP);
   endfunction : is_gp

   // ------------------------------------------------------------------
   // Pin synchronisers.
   // ------------------------------------------------------------------

   // Pins are asynchronous to the system clock, so each passes two flops.
   always_ff @(posedge CLK_SYS or negedge RESETN)
   begin
      // Stages start at the pins' idle levels, with the standby rail taken as present.
      // A rail that is present after reset therefore never looks like it just returned.
      if (!RESETN)
      begin
         sync1_r    <= `RTCS_PIN_IDLE;
         sync2_r    <= `RTCS_PIN_IDLE;
         pin_prev_r <= `RTCS_PIN_IDLE;
      end
      else
      begin
         sync1_r    <= {BATTERY_LOW, STANDBY_POR, TRICKLE_SUPPLY, SYSTEM_RESET_IN};
         sync2_r    <= sync1_r;
         pin_prev_r <= sync2_r;
      end
   end

   assign sys_rst      = sync2_r[0];
   assign trickle_rise = sync2_r[1] & ~pin_prev_r[1];
   assign por_evt      = sync2_r[2] & ~pin_prev_r[2];
   assign batt_low     = sync2_r[3];

   // ------------------------------------------------------------------
   // Bus decode.
   // ------------------------------------------------------------------

   // Only whole-word transfers inside the 1 KiB window are mapped; others read zero.
   assign acc      = HSEL & HTRANS[1] & HREADY;
   assign a_map    = (HADDR[31:10] == 22'h00_0000) & (HADDR[1:0] == 2'h0) & (HSIZE == `RTCS_HSIZE_WORD);
   assign a_key    = HADDR[9:2];
   assign rd_flags = acc & ~HWRITE & a_map & (a_key == `RTCS_KEY_FLAGS);
   assign wr_ctrl  = wr_pend_r & (wr_key_r == `RTCS_KEY_CTRL);

   // Read value mux; reserved bits come back as zero.
   always_comb
   begin
      rd_val = `RTCS_RST_BYTE;
      if (a_map)
      begin
         if (is_gp(a_key))
            rd_val = ram[a_key];
         else
         begin
            case (a_key)
               `RTCS_KEY_CTRL:  rd_val = ctrl_r;
               // Summary bit derives from the same flags that drive the pin.
               `RTCS_KEY_FLAGS: rd_val = flags_r | {irq_any(flags_r, ctrl_r), 7'h00};
               // Lower bits vanish during an update or with the date alarm off.
               `RTCS_KEY_VALID: rd_val = {valid_r, 7'h00} |
                                ((UPDATE_BUSY | ~daen_r) ? `RTCS_RST_BYTE : date_r);
               `RTCS_KEY_AUX:   rd_val = {UPDATE_BUSY, 5'h00, power_req_r, daen_r};
               `RTCS_KEY_PWR:   rd_val = pwr_r;
               default:         rd_val = `RTCS_RST_BYTE;
            endcase
         end
      end
   end

   // ------------------------------------------------------------------
   // Bus slave handshake.
   // ------------------------------------------------------------------

   // Reads finish with no wait; writes take one wait state so a following read sees new data.
   always_ff @(posedge CLK_SYS or negedge RESETN)
   begin
      if (!RESETN)
      begin
         HREADYOUT <= 1'b1;
         HRESP     <= 1'b0;
         wr_pend_r <= 1'b0;
         wr_key_r  <= `RTCS_RST_BYTE;
         HRDATA    <= `RTCS_RST_WORD;
      end
      else
      begin
         HRESP     <= 1'b0;
         HREADYOUT <= ~(acc & HWRITE);
         wr_pend_r <= acc & HWRITE & a_map;
         if (acc & HWRITE)
            wr_key_r <= a_key;
         // Read data is latched at the address edge, before the flags clear.
         if (acc & ~HWRITE)
            HRDATA <= {24'h00_0000, rd_val};
      end
   end

   // ------------------------------------------------------------------
   // Control register next value.
   // ------------------------------------------------------------------

   // Halt going high drops the update enable; system reset drops all three enables.
   always_comb
   begin
      ctrl_nxt = ctrl_r;
      if (wr_ctrl)
      begin
         ctrl_nxt = HWDATA[7:0] & `RTCS_CTRL_WMASK;
         if (HWDATA[`RTCS_B_HALT] & ~ctrl_r[`RTCS_B_HALT])
            ctrl_nxt[`RTCS_B_UIE] = 1'b0;
      end
      if (sys_rst)
      begin
         ctrl_nxt[`RTCS_B_PIE] = 1'b0;
         ctrl_nxt[`RTCS_B_AIE] = 1'b0;
         ctrl_nxt[`RTCS_B_UIE] = 1'b0;
      end
   end

   // ------------------------------------------------------------------
   // Flag next value.
   // ------------------------------------------------------------------

   // Clear only what the read returned as one, then let new events set; set wins.
   always_comb
   begin
      flags_nxt = flags_r;
      if (rd_flags)
         flags_nxt = flags_r & ~rd_val;
      if (pf_evt)
         flags_nxt[`RTCS_F_PF] = 1'b1;
      if (ALARM_MATCH)
         flags_nxt[`RTCS_F_AF] = 1'b1;
      if (UPDATE_DONE)
         flags_nxt[`RTCS_F_UF] = 1'b1;
      flags_nxt[`RTCS_F_ANY] = 1'b0;
      flags_nxt = flags_nxt & ~`RTCS_FLAG_LOW;
      if (sys_rst)
         flags_nxt = `RTCS_RST_BYTE;
   end

   assign pf_evt = PERIODIC_TAP & ~tap_prev_r;

   // ------------------------------------------------------------------
   // Flags, enables and the interrupt pin.
   // ------------------------------------------------------------------

   // The pin is loaded from next values so it always matches the summary bit.
   always_ff @(posedge CLK_SYS or negedge RESETN)
   begin
      if (!RESETN)
      begin
         ctrl_r     <= `RTCS_RST_BYTE;
         flags_r    <= `RTCS_RST_BYTE;
         tap_prev_r <= 1'b0;
         IRQ_OUT_N  <= 1'b1;
      end
      else
      begin
         ctrl_r     <= ctrl_nxt;
         flags_r    <= flags_nxt;
         tap_prev_r <= PERIODIC_TAP;
         IRQ_OUT_N  <= ~irq_any(flags_nxt, ctrl_nxt);
      end
   end

   // ------------------------------------------------------------------
   // Validity, date alarm and auxiliary control.
   // ------------------------------------------------------------------

   // Low battery wins over a read that would set the valid bit.
   always_ff @(posedge CLK_SYS or negedge RESETN)
   begin
      if (!RESETN)
      begin
         valid_r <= 1'b0;
         date_r  <= `RTCS_RST_BYTE;
         daen_r  <= 1'b0;
      end
      else
      begin
         if (batt_low)
            valid_r <= 1'b0;
         else if (acc & ~HWRITE & a_map & (a_key == `RTCS_KEY_VALID))
            valid_r <= 1'b1;
         // System reset leaves the date value alone; writes during update are dropped.
         if (wr_pend_r & (wr_key_r == `RTCS_KEY_VALID) & ~UPDATE_BUSY)
            date_r <= HWDATA[7:0] & `RTCS_DATE_MASK;
         if (wr_pend_r & (wr_key_r == `RTCS_KEY_AUX))
            daen_r <= HWDATA[`RTCS_A_DAEN];
      end
   end

   // ------------------------------------------------------------------
   // Battery backed power wake control.
   // ------------------------------------------------------------------

   // Only the battery reset clears this register; system reset does not.
   always_ff @(posedge CLK_SYS or negedge RESETN)
   begin
      if (!RESETN)
         pwr_r <= `RTCS_RST_BYTE;
      else if (wr_pend_r & (wr_key_r == `RTCS_KEY_PWR))
         pwr_r <= HWDATA[7:0] & `RTCS_PWR_WMASK;
   end

   // The power-on request latches until software clears it or a stay-off reset arrives.
   // Setting both standby reset bits at once is left to software to avoid; stay-off wins here.
   always_ff @(posedge CLK_SYS or negedge RESETN)
   begin
      if (!RESETN)
      begin
         alarm_missed_r <= 1'b0;
         power_req_r    <= 1'b0;
      end
      else
      begin
         if (trickle_rise)
            alarm_missed_r <= 1'b0;
         else if (ALARM_MATCH & ~sync2_r[1] & pwr_r[`RTCS_P_REM])
            alarm_missed_r <= 1'b1;
         if (por_evt & pwr_r[`RTCS_P_POFF])
            power_req_r <= 1'b0;
         else if (por_evt & pwr_r[`RTCS_P_PON])
            power_req_r <= 1'b1;
         else if (trickle_rise & alarm_missed_r)
            power_req_r <= 1'b1;
         else if (wr_pend_r & (wr_key_r == `RTCS_KEY_AUX) & HWDATA[`RTCS_A_PCLR])
            power_req_r <= 1'b0;
      end
   end

   // ------------------------------------------------------------------
   // General purpose CMOS storage.
   // ------------------------------------------------------------------

   // No reset: the contents live on the battery and are never blocked by updates.
   always_ff @(posedge CLK_SYS)
   begin
      if (wr_pend_r & is_gp(wr_key_r))
         ram[wr_key_r] <= HWDATA[7:0];
   end

   // ------------------------------------------------------------------
   // Registered side outputs.
   // ------------------------------------------------------------------

   // The pin is open drain: it only ever pulls low, so the data bit is held at zero.
   always_ff @(posedge CLK_SYS or negedge RESETN)
   begin
      if (!RESETN)
      begin
         SUPPLY_TURN_ON_N_O  <= 1'b0;
         SUPPLY_TURN_ON_N_OE <= 1'b0;
         BINARY_FORMAT_SEL   <= 1'b0;
         HOUR_24_SEL         <= 1'b0;
         UPDATE_HALT         <= 1'b0;
         CRYSTAL_LOAD_SEL    <= 1'b0;
         DATE_ALARM_EN       <= 1'b0;
      end
      else
      begin
         SUPPLY_TURN_ON_N_O  <= 1'b0;
         SUPPLY_TURN_ON_N_OE <= power_req_r;
         BINARY_FORMAT_SEL   <= ctrl_r[`RTCS_B_BIN];
         HOUR_24_SEL         <= ctrl_r[`RTCS_B_H24];
         UPDATE_HALT         <= ctrl_r[`RTCS_B_HALT];
         CRYSTAL_LOAD_SEL    <= pwr_r[`RTCS_P_XTAL];
         DATE_ALARM_EN       <= daen_r;
      end
   end

   // ------------------------------------------------------------------
   // Checks.
   // ------------------------------------------------------------------

   chk_irq_summary_pin: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
      IRQ_OUT_N == ~irq_any(flags_r, ctrl_r))
      else $error("interrupt pin disagrees with summary flag");

   chk_flag_read_clear: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
      rd_flags & ~pf_evt & ~ALARM_MATCH & ~UPDATE_DONE |=> flags_r == `RTCS_RST_BYTE)
      else $error("flag read did not clear flags");

   chk_read_snapshot: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
      rd_flags |=> (HRDATA[6:4] == $past(flags_r[6:4])) && (HRDATA[3:0] == 4'h0))
      else $error("flag read data not the pre-clear value");

   chk_pf_sets: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
      pf_evt & ~sys_rst |=> flags_r[`RTCS_F_PF] ##0 (IRQ_OUT_N == ~ctrl_r[`RTCS_B_PIE] | IRQ_OUT_N == 1'b0))
      else $error("periodic flag missed its edge");

   chk_event_during_read: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
      rd_flags & UPDATE_DONE & ~sys_rst |=> flags_r[`RTCS_F_UF])
      else $error("event during read was lost");

   chk_af_irq: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
      ALARM_MATCH & ~sys_rst & ctrl_nxt[`RTCS_B_AIE] |=> !IRQ_OUT_N)
      else $error("alarm with enable did not assert the interrupt");

   chk_uie_halt_clear: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
      wr_ctrl & HWDATA[`RTCS_B_HALT] & ~ctrl_r[`RTCS_B_HALT] |=> !ctrl_r[`RTCS_B_UIE])
      else $error("update enable survived halt going high");

   chk_sys_reset_clear: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
      sys_rst |=> (ctrl_r[6:4] == 3'h0) && (flags_r == `RTCS_RST_BYTE) && IRQ_OUT_N)
      else $error("system reset left enables or flags set");

   chk_por_power_on: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
      por_evt & pwr_r[`RTCS_P_PON] & ~pwr_r[`RTCS_P_POFF] |=> ##1 SUPPLY_TURN_ON_N_OE)
      else $error("standby reset did not drive power-on");

   chk_valid_on_read: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
      $rose(valid_r) |-> $past(acc & ~HWRITE & a_map & (a_key == `RTCS_KEY_VALID)))
      else $error("valid bit set without a read");

endmodule : rtcs_irq_ctrl

// ---- tb/rtcs_host.sv ----
// Host side bus model issuing single word transfers.
`timescale 1ns/10ps
module rtcs_host
(
   input  wire logic             CLK_SYS,
   input  wire logic             HREADY,
   input  wire logic [31:0]      HRDATA,
   output logic                  HSEL,
   output rtcs_pkg::rtcs_htrans_t HTRANS,
   output logic [31:0]           HADDR,
   output logic                  HWRITE,
   output logic [31:0]           HWDATA
);
   import rtcs_pkg::*;
   // Bus stays idle until the first transfer.
   initial
   begin
      HSEL = 1'b0;
      HTRANS = RTCS_IDLE;
      HADDR = 32'h0000_0000;
      HWRITE = 1'b0;
      HWDATA = 32'h0000_0000;
   end
   // Each phase is held until ready is sampled high; no wait count is assumed.
   task xfer(input logic w, input logic [7:0] k, input logic [7:0] d, output logic [7:0] q);
      @(posedge CLK_SYS);
      HSEL <= 1'b1;
      HTRANS <= RTCS_NONSEQ;
      HADDR <= {22'h00_0000, k, 2'h0};
      HWRITE <= w;
      do @(posedge CLK_SYS); while (HREADY !== 1'b1);
      HSEL <= 1'b0;
      HTRANS <= RTCS_IDLE;
      HWDATA <= {24'h00_0000, d};
      do @(posedge CLK_SYS); while (HREADY !== 1'b1);
      q = HRDATA[7:0];
      // Released lines show a changed value so stale data cannot pass.
      HWDATA <= ~HWDATA;
      HADDR <= ~HADDR;
   endtask : xfer
endmodule : rtcs_host

// ---- tb/tb.sv ----
// Self-checking bench of the clock control block.
`timescale 1ns/10ps
`include "rtcs_defines.svh"
module tb;
   import rtcs_pkg::*;
   localparam logic [7:0] KC = `RTCS_KEY_CTRL, KF = `RTCS_KEY_FLAGS, KV = `RTCS_KEY_VALID;
   localparam logic [7:0] KA = `RTCS_KEY_AUX, KP = `RTCS_KEY_PWR;
   logic CLK_SYS = 1'b0, RESETN, SYSTEM_RESET_IN, TRICKLE_SUPPLY, BATTERY_LOW, UPDATE_BUSY;
   logic [3:0] ev;
   logic [2:0] HSIZE = `RTCS_HSIZE_WORD;
   logic [7:0] q;
   wire UPDATE_DONE = ev[0], ALARM_MATCH = ev[1], STANDBY_POR = ev[2], PERIODIC_TAP = ev[3];
   wire HSEL, HWRITE, HREADYOUT, HRESP, IRQ_OUT_N, SUPPLY_TURN_ON_N_O, SUPPLY_TURN_ON_N_OE;
   wire BINARY_FORMAT_SEL, HOUR_24_SEL, UPDATE_HALT, CRYSTAL_LOAD_SEL, DATE_ALARM_EN;
   wire [31:0] HADDR, HWDATA, HRDATA;
   rtcs_htrans_t HTRANS;
   int mismatches = 0, n_tests = 0, cyc = 0;
   rtcs_irq_ctrl u_rtcs_irq_ctrl (.HREADY(HREADYOUT), .*);
   rtcs_host u_rtcs_host (.HREADY(HREADYOUT), .*);
   // Free running 100 MHz clock.
   always #5 CLK_SYS = ~CLK_SYS;
   // A hang is cut short well above the expected run length.
   always @(posedge CLK_SYS)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         mismatches++;
         report_and_stop;
      end
   end
   task report_and_stop;
      if (mismatches == 0 && n_tests > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : report_and_stop
   task chk(input logic [7:0] v, input logic [7:0] e);
      n_tests++;
      if (v !== e)
      begin
         mismatches++;
         $display("unexpected at %0t: saw %h want %h", $time, v, e);
      end
   endtask : chk
   task w(input logic [7:0] k, input logic [7:0] d);
      u_rtcs_host.xfer(1'b1, k, d, q);
   endtask : w
   task rc(input logic [7:0] k, input logic [7:0] e);
      u_rtcs_host.xfer(1'b0, k, 8'h00, q);
      chk(q, e);
   endtask : rc
   // Waits, then looks just after the edge so registered outputs have landed.
   task nap(input int n);
      repeat (n) @(posedge CLK_SYS);
      #1;
   endtask : nap
   // One cycle event pulse on the chosen source.
   task pulse(input int i);
      @(posedge CLK_SYS) ev[i] <= 1'b1;
      @(posedge CLK_SYS) ev[i] <= 1'b0;
      nap(4);
   endtask : pulse
   task t_regs;
      rc(KP, 8'h00);
      rc(KF, 8'h00);
      w(KC, 8'h0F);
      rc(KC, 8'h06);
      chk({6'h00, BINARY_FORMAT_SEL, HOUR_24_SEL}, 8'h03);
      w(KF, 8'hFF);
      chk(8'(HRESP), 8'h00);
      rc(KF, 8'h00);
      rc(8'h05, 8'h00);
   endtask : t_regs
   task t_irq;
      pulse(0);
      pulse(1);
      pulse(3);
      chk(8'(IRQ_OUT_N), 8'h01);
      rc(KF, 8'h70);
      rc(KF, 8'h00);
      pulse(0);
      w(KC, 8'h16);
      chk(8'(IRQ_OUT_N), 8'h00);
      rc(KF, 8'h90);
      nap(2);
      chk(8'(IRQ_OUT_N), 8'h01);
      w(KC, 8'h96);
      rc(KC, 8'h86);
      chk(8'(UPDATE_HALT), 8'h01);
   endtask : t_irq
   task t_valid;
      u_rtcs_host.xfer(1'b0, KV, 8'h00, q);
      rc(KV, 8'h80);
      w(KV, 8'h15);
      rc(KV, 8'h80);
      w(KA, 8'h01);
      nap(1);
      chk(8'(DATE_ALARM_EN), 8'h01);
      rc(KV, 8'h95);
      @(posedge CLK_SYS) UPDATE_BUSY <= 1'b1;
      w(KV, 8'h2A);
      rc(KV, 8'h80);
      w(8'hC0, 8'hA5);
      rc(8'hC0, 8'hA5);
      @(posedge CLK_SYS) UPDATE_BUSY <= 1'b0;
      rc(KV, 8'h95);
      @(posedge CLK_SYS) BATTERY_LOW <= 1'b1;
      nap(4);
      rc(KV, 8'h15);
      @(posedge CLK_SYS) BATTERY_LOW <= 1'b0;
   endtask : t_valid
   task t_power;
      w(KP, 8'hFD);
      rc(KP, 8'h85);
      chk(8'(CRYSTAL_LOAD_SEL), 8'h01);
      pulse(2);
      chk({SUPPLY_TURN_ON_N_OE, SUPPLY_TURN_ON_N_O, 6'h00}, 8'h80);
      w(KP, 8'h02);
      pulse(2);
      chk(8'(SUPPLY_TURN_ON_N_OE), 8'h00);
      w(KP, 8'h01);
      @(posedge CLK_SYS) TRICKLE_SUPPLY <= 1'b0;
      nap(2);
      pulse(1);
      chk(8'(SUPPLY_TURN_ON_N_OE), 8'h00);
      @(posedge CLK_SYS) TRICKLE_SUPPLY <= 1'b1;
      nap(6);
      chk(8'(SUPPLY_TURN_ON_N_OE), 8'h01);
      w(KA, 8'h03);
      nap(1);
      chk(8'(SUPPLY_TURN_ON_N_OE), 8'h00);
   endtask : t_power
   task t_sysrst;
      w(KC, 8'h66);
      pulse(1);
      chk(8'(IRQ_OUT_N), 8'h00);
      @(posedge CLK_SYS) SYSTEM_RESET_IN <= 1'b1;
      nap(5);
      chk(8'(IRQ_OUT_N), 8'h01);
      @(posedge CLK_SYS) SYSTEM_RESET_IN <= 1'b0;
      nap(4);
      rc(KC, 8'h06);
      rc(KF, 8'h00);
      rc(KP, 8'h01);
      rc(KV, 8'h15);
   endtask : t_sysrst
   initial
   begin
      {RESETN, SYSTEM_RESET_IN, BATTERY_LOW, UPDATE_BUSY} = 4'h0;
      ev = 4'h0;
      TRICKLE_SUPPLY = 1'b1;
      repeat (10) @(posedge CLK_SYS);
      RESETN <= 1'b1;
      t_regs;
      t_irq;
      t_valid;
      t_power;
      t_sysrst;
      report_and_stop;
   end
endmodule : tb
